/* shared/bcdc_consts.vh */
// shared constants for the bcd up/down counter display block
`ifndef BCDC_CONSTS_VH
`define BCDC_CONSTS_VH
`define BCDC_CLK_HZ          10000000
`define BCDC_WRAP_DLY_NS     500
`define BCDC_WRAP_WID_NS     100
`define BCDC_SCAN_HZ         2500
`define BCDC_DUTY_RATIO      25
`define BCDC_WRAP_RST_MIN    16'h6000
`define BCDC_MAX_DIGIT       4'h9
`define BCDC_ZERO_COUNT      16'h0000
`define BCDC_FULL_COUNT      16'h9999
`define BCDC_PH_D4           2'h0
`define BCDC_PH_D3           2'h1
`define BCDC_PH_D2           2'h2
`define BCDC_PH_D1           2'h3
`define BCDC_DISP_NORMAL     2'h0
`define BCDC_DISP_OFF        2'h1
`define BCDC_DISP_NOBLANK    2'h2
`endif

/* logic/bcdc_seg_decode.v */
// bcd digit to seven-segment pattern decoder, registered output
`timescale 1ns/10ps
`include "bcdc_consts.vh"
module bcdc_seg_decode (
  input  wire       i_ref_clk, // system clock
  input  wire       i_nrst,    // async reset, active low
  input  wire [3:0] i_digit,   // bcd digit to show
  input  wire       i_blank,   // force all segments off
  output reg  [6:0] o_seg      // segments g..a, active high
);
  reg [6:0] pat; // combinational pattern

  // plain lookup; codes above nine show nothing
  always @* begin
    case (i_digit)
      4'h0: pat = 7'h3F;
      4'h1: pat = 7'h06;
      4'h2: pat = 7'h5B;
      4'h3: pat = 7'h4F;
      4'h4: pat = 7'h66;
      4'h5: pat = 7'h6D;
      4'h6: pat = 7'h7D;
      4'h7: pat = 7'h07;
      4'h8: pat = 7'h7F;
      4'h9: pat = 7'h6F;
      default: pat = 7'h00;
    endcase
  end

  // registered so segments change cleanly
  always @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_seg <= 7'h00;
    end else begin
      o_seg <= i_blank ? 7'h00 : pat;
    end
  end
endmodule

/* logic/bcdc_scan_osc.v */
// scan oscillator: free-running short pulse generator with external overdrive
`timescale 1ns/10ps
`include "bcdc_consts.vh"
module bcdc_scan_osc #(
  parameter integer PERIOD_CYC = `BCDC_CLK_HZ / `BCDC_SCAN_HZ, // cycles per period
  parameter integer PULSE_CYC  = (`BCDC_CLK_HZ / `BCDC_SCAN_HZ) / `BCDC_DUTY_RATIO // short pulse length
) (
  input  wire i_ref_clk,  // system clock
  input  wire i_nrst,     // async reset, active low
  input  wire i_restart,  // restart period from zero
  input  wire i_ext_en,   // use external scan node
  input  wire i_ext_scan, // external scan level, high blanks
  output reg  o_blank,    // high during short pulse
  output reg  o_advance   // one-cycle pulse per period
);
  reg [15:0] cnt_r;   // period counter
  reg        ext_d_r; // previous external level
  wire       int_p;   // internal pulse level

  assign int_p = (cnt_r < PULSE_CYC[15:0]);

  // counter wraps each period; restart aligns the sequencer
  always @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_r     <= 16'h0000;
      ext_d_r   <= 1'b0;
      o_blank   <= 1'b1;
      o_advance <= 1'b0;
    end else begin
      ext_d_r <= i_ext_scan;
      if (i_restart || cnt_r == PERIOD_CYC[15:0] - 16'h0001) begin
        cnt_r <= 16'h0000;
      end else begin
        cnt_r <= cnt_r + 16'h0001;
      end
      if (i_ext_en) begin
        // external source: advance on its rising edge, blank while high
        o_blank   <= i_ext_scan;
        o_advance <= i_ext_scan & ~ext_d_r;
      end else begin
        // advance at the end of a period: after a restart the first digit
        // keeps its strobe for a full period before its data is taken
        o_blank   <= int_p;
        o_advance <= (cnt_r == PERIOD_CYC[15:0] - 16'h0001) && !i_restart;
      end
    end
  end
endmodule

/* logic/bcdc_counter_top.v */
// four decade bcd up/down counter with compare, latches and display scan
`timescale 1ns/10ps
`include "bcdc_consts.vh"
module bcdc_counter_top #(
  parameter integer CLK_HZ = `BCDC_CLK_HZ // system clock rate
) (
  input  wire       i_ref_clk,            // system clock, 10 MHz
  input  wire       i_nrst,               // system reset, active low
  input  wire       i_pulse_in,           // count pulse input
  input  wire       i_count_direction,    // high counts up
  input  wire       i_latch_transfer_n,   // low copies counter to latches
  input  wire       i_counter_reset_n,    // counter reset, active low
  input  wire [1:0] i_display_mode,       // normal, off or no-blank
  input  wire       i_counter_preset_ctl, // load counter from bcd port
  input  wire       i_register_preset_ctl,// load compare from bcd port
  input  wire       i_bcd_port_off,       // float bcd port (low on a pin)
  input  wire [3:0] i_bcd_in,             // bcd port input levels
  input  wire       i_mux_rate_node,      // external scan overdrive level
  input  wire       i_ext_scan_en,        // external scan source fitted
  output reg        o_wrap_pulse,         // carry/borrow pulse
  output reg        o_match_n,            // low when counter equals compare
  output reg        o_count_empty_n,      // low when counter is zero
  output reg  [6:0] o_seg,                // segment pattern g..a
  output reg  [3:0] o_digit_strobe,       // [3]=digit_strobe_4 .. [0]=digit_strobe_1
  output reg  [3:0] o_bcd_out,            // bcd port output data
  output reg        o_bcd_oe_n,           // bcd port enable, low drives
  output wire       o_preset_busy         // preset sequence running
);
  localparam integer WRAP_DLY_CYC = (`BCDC_WRAP_DLY_NS * (CLK_HZ / 1000000) + 999) / 1000; // rounded up
  localparam integer WRAP_WID_CYC = (`BCDC_WRAP_WID_NS * (CLK_HZ / 1000000) + 999) / 1000; // rounded up
  localparam [1:0]   PS_IDLE = 2'h0; // normal running
  localparam [1:0]   PS_LOAD = 2'h1; // loading digits d4..d1
  localparam [1:0]   PS_DONE = 2'h2; // cycle end, resample

  reg  [2:0]  rst_sync_r;   // reset synchroniser, [0] first stage
  reg  [2:0]  pin_r;        // sampled pulse input history
  reg         dir_r;        // sampled direction
  reg         lt_r;         // sampled latch transfer
  reg         lc_r;         // sampled counter preset
  reg         lr_r;         // sampled register preset
  reg  [15:0] cnt_r;        // live counter, four bcd digits
  reg  [15:0] cmp_r;        // compare register
  reg  [15:0] lat_r;        // output latches
  reg  [1:0]  phase_r;      // digit phase, 0 = most significant
  reg  [1:0]  ps_r;         // preset state
  reg         ld_cnt_r;     // this load cycle writes counter
  reg         ld_reg_r;     // this load cycle writes compare
  reg  [7:0]  wdly_r;       // wrap delay countdown
  reg  [7:0]  wwid_r;       // wrap width countdown
  reg  [15:0] inc_v;        // counter plus one in bcd
  reg  [15:0] dec_v;        // counter minus one in bcd
  reg         lz_v;         // current digit is a leading zero
  reg  [3:0]  dsel_v;       // latched digit for this phase
  wire        rst_n_s;      // synchronised counter reset
  wire        cnt_edge;     // rising count edge
  wire        scan_blank;   // short pulse in progress
  wire        scan_adv;     // advance the sequencer
  wire        restart;      // begin a preset sequence
  wire        preset_any;   // either preset control high
  integer     k;            // digit loop index

  assign rst_n_s       = rst_sync_r[2];
  assign cnt_edge      = pin_r[1] & ~pin_r[2];
  assign preset_any    = lc_r | lr_r;
  assign restart       = (ps_r == PS_IDLE) && preset_any;
  assign o_preset_busy = (ps_r != PS_IDLE);

  // reset synchroniser; first stage feeds only the second
  always @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_sync_r <= 3'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[1], rst_sync_r[0], i_counter_reset_n};
    end
  end

  // input sampling with the local clock
  always @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pin_r <= 3'h0;
      dir_r <= 1'b1;
      lt_r  <= 1'b1;
      lc_r  <= 1'b0;
      lr_r  <= 1'b0;
    end else begin
      pin_r <= {pin_r[1:0], i_pulse_in};
      dir_r <= i_count_direction;
      lt_r  <= i_latch_transfer_n;
      lc_r  <= i_counter_preset_ctl;
      lr_r  <= i_register_preset_ctl;
    end
  end

  // bcd increment and decrement, ripple through decades
  always @* begin
    inc_v = cnt_r;
    dec_v = cnt_r;
    begin : incdec
      reg ci;
      reg bi;
      ci = 1'b1;
      bi = 1'b1;
      for (k = 0; k < 4; k = k + 1) begin
        if (ci) begin
          if (cnt_r[4*k +: 4] == `BCDC_MAX_DIGIT) begin
            inc_v[4*k +: 4] = 4'h0;
          end else begin
            inc_v[4*k +: 4] = cnt_r[4*k +: 4] + 4'h1;
            ci = 1'b0;
          end
        end
        if (bi) begin
          if (cnt_r[4*k +: 4] == 4'h0) begin
            dec_v[4*k +: 4] = `BCDC_MAX_DIGIT;
          end else begin
            dec_v[4*k +: 4] = cnt_r[4*k +: 4] - 4'h1;
            bi = 1'b0;
          end
        end
      end
    end
  end

  // counter: async-style clear from synced reset, presets, counting
  always @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_r <= `BCDC_ZERO_COUNT;
    end else if (!rst_n_s) begin
      cnt_r <= `BCDC_ZERO_COUNT;
    end else if (ps_r == PS_LOAD && ld_cnt_r && scan_adv) begin
      cnt_r[4*(3-phase_r) +: 4] <= i_bcd_in;
    end else if (cnt_edge && !lc_r && ps_r == PS_IDLE) begin
      cnt_r <= dir_r ? inc_v : dec_v;
    end
  end

  // compare register: only preset writes it, reset alone keeps it
  always @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cmp_r <= `BCDC_ZERO_COUNT;
    end else if (!rst_n_s && lr_r) begin
      cmp_r <= `BCDC_ZERO_COUNT;
    end else if (ps_r == PS_LOAD && ld_reg_r && scan_adv) begin
      cmp_r[4*(3-phase_r) +: 4] <= rst_n_s ? i_bcd_in : 4'h0;
    end
  end

  // output latches follow the counter while transfer is low
  always @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      lat_r <= `BCDC_ZERO_COUNT;
    end else if (!lt_r) begin
      lat_r <= cnt_r;
    end
  end

  // wrap pulse: arm on rollover or on reset from 6000 up, then delay and stretch
  always @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wdly_r       <= 8'h00;
      wwid_r       <= 8'h00;
      o_wrap_pulse <= 1'b0;
    end else begin
      if (rst_sync_r[2] && !rst_sync_r[1] && cnt_r >= `BCDC_WRAP_RST_MIN) begin
        wdly_r <= WRAP_DLY_CYC[7:0];
      end else if (cnt_edge && !lc_r && ps_r == PS_IDLE && rst_n_s &&
                   ((dir_r && cnt_r == `BCDC_FULL_COUNT) ||
                    (!dir_r && cnt_r == `BCDC_ZERO_COUNT))) begin
        wdly_r <= WRAP_DLY_CYC[7:0];
      end else if (wdly_r != 8'h00) begin
        wdly_r <= wdly_r - 8'h01;
      end
      if (wdly_r == 8'h01) begin
        wwid_r <= WRAP_WID_CYC[7:0];
      end else if (wwid_r != 8'h00) begin
        wwid_r <= wwid_r - 8'h01;
      end
      o_wrap_pulse <= (wwid_r != 8'h00);
    end
  end

  // match and zero flags, registered
  always @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_match_n       <= 1'b0;
      o_count_empty_n <= 1'b0;
    end else begin
      o_match_n       <= (cnt_r != cmp_r);
      o_count_empty_n <= (cnt_r != `BCDC_ZERO_COUNT);
    end
  end

  // scan oscillator, internal while a preset is pending or runs, or when no external source is fitted
  bcdc_scan_osc u_osc (
    .i_ref_clk  (i_ref_clk),
    .i_nrst     (i_nrst),
    .i_restart  (restart),
    .i_ext_en   (i_ext_scan_en && ps_r == PS_IDLE && !preset_any),
    .i_ext_scan (i_mux_rate_node),
    .o_blank    (scan_blank),
    .o_advance  (scan_adv)
  );

  // preset sequencer: a full d4..d1 pass, resample at end
  always @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ps_r     <= PS_IDLE;
      ld_cnt_r <= 1'b0;
      ld_reg_r <= 1'b0;
    end else begin
      case (ps_r)
        PS_IDLE: begin
          if (preset_any) begin
            ps_r     <= PS_LOAD;
            ld_cnt_r <= lc_r;
            ld_reg_r <= lr_r;
          end
        end
        PS_LOAD: begin
          if (scan_adv && phase_r == `BCDC_PH_D1) begin
            ps_r <= PS_DONE;
          end
        end
        PS_DONE: begin
          // repeat while either control is still high
          ps_r     <= preset_any ? PS_LOAD : PS_IDLE;
          ld_cnt_r <= lc_r;
          ld_reg_r <= lr_r;
        end
        default: ps_r <= PS_IDLE;
      endcase
    end
  end

  // four-phase digit sequencer, reset to d4 when a preset begins
  always @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      phase_r <= `BCDC_PH_D4;
    end else if (restart) begin
      phase_r <= `BCDC_PH_D4;
    end else if (scan_adv) begin
      phase_r <= phase_r + 2'h1;
    end
  end

  // pick the latched digit and judge leading zeros
  always @* begin
    dsel_v = lat_r[4*(3-phase_r) +: 4];
    case (phase_r)
      `BCDC_PH_D4: lz_v = (lat_r[15:12] == 4'h0);
      `BCDC_PH_D3: lz_v = (lat_r[15:8] == 8'h00);
      `BCDC_PH_D2: lz_v = (lat_r[15:4] == 12'h000);
      default:     lz_v = 1'b0; // last digit always shown
    endcase
  end

  // segment decoder; blanked by display-off or, in normal mode only, by a leading zero
  bcdc_seg_decode u_dec (
    .i_ref_clk (i_ref_clk),
    .i_nrst    (i_nrst),
    .i_digit   (dsel_v),
    .i_blank   ((i_display_mode == `BCDC_DISP_OFF) ||
                (i_display_mode == `BCDC_DISP_NORMAL && lz_v)),
    .o_seg     (o_seg)
  );

  // digit strobes, one-hot per phase, off during the short pulse
  always @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_digit_strobe <= 4'h0;
    end else if (scan_blank || i_display_mode == `BCDC_DISP_OFF) begin
      o_digit_strobe <= 4'h0;
    end else begin
      o_digit_strobe <= 4'h8 >> phase_r;
    end
  end

  // bcd port: drives latched digit in scan step when no preset is pending or running, the port is not floated and the display is not off
  always @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_bcd_out  <= 4'h0;
      o_bcd_oe_n <= 1'b1;
    end else begin
      o_bcd_out  <= dsel_v;
      o_bcd_oe_n <= preset_any || o_preset_busy || i_bcd_port_off ||
                    i_display_mode == `BCDC_DISP_OFF;
    end
  end
endmodule

/* tb/bcdc_checker.sv */
// concurrent checks on the ports of the bcd counter display top
`timescale 1ns/10ps
module bcdc_checker (
  input wire       i_ref_clk,         // system clock
  input wire       i_nrst,            // system reset, active low
  input wire       i_counter_reset_n, // counter reset, active low
  input wire [1:0] i_display_mode,    // display control
  input wire       i_bcd_port_off,    // float bcd port
  input wire       i_mux_rate_node,   // external scan level
  input wire       i_ext_scan_en,     // external scan selected
  input wire       o_wrap_pulse,      // carry/borrow pulse
  input wire       o_count_empty_n,   // low at zero count
  input wire [6:0] o_seg,             // segments
  input wire [3:0] o_digit_strobe,    // digit strobes, bit3 most significant
  input wire       o_bcd_oe_n,        // bcd port enable, low drives
  input wire       o_preset_busy      // preset sequence running
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  reg [3:0] last_r; // last lit digit, zero while the order is unknown
  // track the scan phase only where every digit is lit in turn
  always @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst)
      last_r <= 4'h0;
    else if (o_preset_busy || i_display_mode != 2'h2)
      last_r <= 4'h0; // preset restarts the phase, blanking hides it
    else if (o_digit_strobe != 4'h0)
      last_r <= o_digit_strobe;
  end
  a_strobe_one_hot: assert property ($onehot0(o_digit_strobe))
    else $error("more than one digit strobe lit");
  a_strobe_gap_blank: assert property (o_digit_strobe != 4'h0 && $past(o_digit_strobe) != 4'h0
    |-> o_digit_strobe == $past(o_digit_strobe)) else $error("digit changed without blank gap");
  a_scan_order_msd: assert property (o_digit_strobe != 4'h0 && last_r != 4'h0 && o_digit_strobe != last_r
    |-> o_digit_strobe == {last_r[0], last_r[3:1]}) else $error("digit scan order broken");
  a_display_off_dark: assert property ((i_display_mode == 2'h1)[*6]
    |-> o_digit_strobe == 4'h0 && o_seg == 7'h00) else $error("display lit while off");
  a_ext_scan_blank: assert property ((i_ext_scan_en && i_mux_rate_node && !o_preset_busy)[*4]
    |-> o_digit_strobe == 4'h0) else $error("digit lit while external scan high");
  a_wrap_one_cycle: assert property ($rose(o_wrap_pulse) |=> !o_wrap_pulse)
    else $error("wrap pulse wider than one cycle");
  a_preset_port_input: assert property (o_preset_busy[*2] |-> o_bcd_oe_n)
    else $error("bcd port driven during preset");
  a_port_off_float: assert property (i_bcd_port_off[*2] |-> o_bcd_oe_n)
    else $error("bcd port driven while floated");
  a_reset_clears_zero: assert property ((!i_counter_reset_n)[*6] |-> !o_count_empty_n)
    else $error("counter not zero under reset");
  c_wrap_seen: cover property ($rose(o_wrap_pulse));
  c_preset_done: cover property ($fell(o_preset_busy));
  c_ext_last_digit: cover property (i_ext_scan_en && o_digit_strobe == 4'h1);
endmodule
bind bcdc_counter_top bcdc_checker u_chk (.i_ref_clk, .i_nrst, .i_counter_reset_n, .i_display_mode,
  .i_bcd_port_off, .i_mux_rate_node, .i_ext_scan_en, .o_wrap_pulse, .o_count_empty_n, .o_seg,
  .o_digit_strobe, .o_bcd_oe_n, .o_preset_busy);

/* tb/bcdc_far_model.sv */
// thumbwheel switch bank and external scan source facing the display block
`timescale 1ns/10ps
module bcdc_far_model #(
  parameter integer SCAN_PER = 1000, // scan period in cycles, 10 kHz
  parameter integer SCAN_HI  = 40    // blank time per period, 4 us
) (
  input  wire        i_ref_clk,               // system clock
  input  wire [3:0]  i_digit_strobe,          // digit strobes from the block
  input  wire [15:0] i_wheel,                 // switch setting, four digits
  input  wire        i_scan_en,               // external scan fitted
  output reg  [3:0]  o_bcd_in = 4'h0,         // switch levels on the port
  output reg         o_mux_rate_node = 1'b0   // external scan level
);
  integer cnt = 0; // position in the scan period
  // scan source and strobe-selected switch digit
  always @(posedge i_ref_clk) begin
    cnt <= (cnt + 1) % SCAN_PER;
    o_mux_rate_node <= i_scan_en && (cnt < SCAN_HI); // short high phase, rate under 20 kHz
    // digit held through the gap so it is valid at the strobe's trailing edge
    case (i_digit_strobe)
      4'h8: o_bcd_in <= i_wheel[15:12];
      4'h4: o_bcd_in <= i_wheel[11:8];
      4'h2: o_bcd_in <= i_wheel[7:4];
      4'h1: o_bcd_in <= i_wheel[3:0];
      default: ;
    endcase
  end
endmodule

/* tb/test_bcd_updown_counter_display.sv */
// self-checking bench for the bcd up/down counter display block
`timescale 1ns/10ps
module test_bcd_updown_counter_display;
  reg        clk = 1'b0;                 // 10 MHz reference
  reg        nrst = 1'b0;                // system reset
  reg        pin = 1'b0;                 // count input
  reg        dir = 1'b1;                 // count direction
  reg        lt_n = 1'b1;                // latch transfer
  reg        crst_n = 1'b1;              // counter reset
  reg [1:0]  mode = 2'h2;                // display mode, no blanking
  reg        lc = 1'b0;                  // counter preset control
  reg        lr = 1'b0;                  // compare preset control
  reg        poff = 1'b0;                // bcd port float
  reg        ext = 1'b0;                 // external scan enable
  reg        up;                         // drawn direction
  reg [15:0] wheel = 16'h0000;           // switch setting
  reg [15:0] cnt = 16'h0000;             // bench copy of the counter
  reg [15:0] got;                        // digits read from the port
  reg [27:0] gseg;                       // segment patterns seen, d4 on top
  wire [3:0] bcd_in, strb, bcd_out;      // port and strobes
  wire [6:0] seg;                        // segments
  wire       mux, wrap, match_n, empty_n, oe_n, busy;
  integer    failures = 0, tests_run = 0, seed = 15, wraps = 0, ew = 0, n, i, k;
  always #50 clk = ~clk;
  // count wrap pulses as the block drives them
  always @(posedge clk) if (wrap === 1'b1) wraps <= wraps + 1;
  bcdc_counter_top DUT (.i_ref_clk(clk), .i_nrst(nrst), .i_pulse_in(pin), .i_count_direction(dir),
    .i_latch_transfer_n(lt_n), .i_counter_reset_n(crst_n), .i_display_mode(mode),
    .i_counter_preset_ctl(lc), .i_register_preset_ctl(lr), .i_bcd_port_off(poff), .i_bcd_in(bcd_in),
    .i_mux_rate_node(mux), .i_ext_scan_en(ext), .o_wrap_pulse(wrap), .o_match_n(match_n),
    .o_count_empty_n(empty_n), .o_seg(seg), .o_digit_strobe(strb), .o_bcd_out(bcd_out),
    .o_bcd_oe_n(oe_n), .o_preset_busy(busy));
  bcdc_far_model u_far (.i_ref_clk(clk), .i_digit_strobe(strb), .i_wheel(wheel), .i_scan_en(ext),
    .o_bcd_in(bcd_in), .o_mux_rate_node(mux));
  task chk(input [27:0] g, input [27:0] e);
    begin
      tests_run = tests_run + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  // flags expected from the bench counter and the loaded compare value
  task chk_flags(input [15:0] cmpv);
    chk({14'h0, empty_n, match_n}, {14'h0, cnt != 16'h0, cnt != cmpv});
  endtask
  task cyc(input integer c);
    repeat (c) @(posedge clk);
  endtask
  task test_done;
    begin
      $display("counts: run=%0d failed=%0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  task tmo;
    begin
      failures = failures + 1;
      test_done;
    end
  endtask
  // seven-segment pattern, bit0 = segment a .. bit6 = segment g
  function [6:0] seg7(input [3:0] d);
    case (d)
      4'h0: seg7 = 7'h3F;
      4'h1: seg7 = 7'h06;
      4'h2: seg7 = 7'h5B;
      4'h3: seg7 = 7'h4F;
      4'h4: seg7 = 7'h66;
      4'h5: seg7 = 7'h6D;
      4'h6: seg7 = 7'h7D;
      4'h7: seg7 = 7'h07;
      4'h8: seg7 = 7'h7F;
      4'h9: seg7 = 7'h6F;
      default: seg7 = 7'h00;
    endcase
  endfunction
  // next bcd count, wrapping both ways
  function [15:0] nxt(input [15:0] v, input u);
    integer d, j;
    begin
      d = v[15:12] * 1000 + v[11:8] * 100 + v[7:4] * 10 + v[3:0];
      d = (d + (u ? 1 : 9999)) % 10000;
      for (j = 0; j < 4; j = j + 1) begin
        nxt[j*4 +: 4] = 4'(d % 10);
        d = d / 10;
      end
    end
  endfunction
  // one count edge; the bench counter moves only where it should
  task pulse(input u, input counts);
    begin
      @(posedge clk) dir <= u;
      cyc(2);
      pin <= 1'b1;
      cyc(3);
      pin <= 1'b0;
      cyc(14);
      if (counts) cnt = nxt(cnt, u);
    end
  endtask
  task preset(input [15:0] v, input is_reg);
    begin
      wheel <= v;
      if (is_reg) lr <= 1'b1;
      else lc <= 1'b1;
      for (n = 0; n < 30 && busy !== 1'b1; n = n + 1) @(posedge clk);
      if (busy !== 1'b1) tmo;
      lr <= 1'b0;
      lc <= 1'b0;
      pulse(1, 0);
      for (n = 0; n < 60000 && busy !== 1'b0; n = n + 1) @(posedge clk);
      if (busy !== 1'b0) tmo;
      if (!is_reg) cnt = v;
      cyc(4);
    end
  endtask
  // each digit must follow the last within one scan step, most significant first
  task read_disp;
    begin
      got = 16'h0;
      gseg = 28'h0;
      for (k = 3; k >= 0; k = k - 1) begin
        for (n = 0; n < (k == 3 ? 6000 : 1100) && strb !== (4'h1 << k); n = n + 1) @(posedge clk);
        if (strb !== (4'h1 << k)) tmo;
        cyc(2);
        got[k*4 +: 4] = bcd_out;
        gseg[k*7 +: 7] = seg;
        chk({27'h0, oe_n}, 28'h0);
      end
    end
  endtask
  initial begin
    cyc(12);
    nrst <= 1'b1;
    cyc(2);
    chk_flags(16'h0000);
    preset(16'h9999, 1);
    chk_flags(16'h9999);
    pulse(0, 1);
    ew = 1;
    chk(wraps[15:0], ew[15:0]);
    chk_flags(16'h9999);
    $display("test compare preset and borrow done");
    for (i = 0; i < 80; i = i + 1) begin
      up = ($random(seed) % 2) != 0;
      poff <= ($random(seed) % 4) == 0;
      if (cnt == (up ? 16'h9999 : 16'h0000)) ew = ew + 1;
      pulse(up, 1);
      chk_flags(16'h9999);
      chk(wraps[15:0], ew[15:0]);
    end
    $display("test random counting done");
    for (i = 0; i < 100 && cnt < 16'h6000; i = i + 1) begin
      if (cnt == 16'h0000) ew = ew + 1;
      pulse(0, 1);
    end
    crst_n <= 1'b0;
    pulse(1, 0);
    crst_n <= 1'b1;
    cyc(12);
    ew = ew + 1;
    cnt = 16'h0000;
    chk(wraps[15:0], ew[15:0]);
    chk_flags(16'h9999);
    $display("test counter reset done");
    preset(16'h1234, 0);
    chk_flags(16'h9999);
    ext <= 1'b1;
    poff <= 1'b0;
    lt_n <= 1'b0;
    cyc(4);
    lt_n <= 1'b1;
    pulse(1, 1);
    read_disp;
    chk(got, 16'h1234);
    chk(gseg, {seg7(4'h1), seg7(4'h2), seg7(4'h3), seg7(4'h4)});
    chk(wraps[15:0], ew[15:0]);
    $display("test counter preset and display done");
    mode <= 2'h1;
    poff <= 1'b1;
    cyc(2000);
    // clear from below 6000 and latch zero: no wrap, leading zeros blank
    crst_n <= 1'b0;
    cyc(12);
    crst_n <= 1'b1;
    lt_n <= 1'b0;
    cyc(12);
    lt_n <= 1'b1;
    cnt = 16'h0000;
    mode <= 2'h0;
    poff <= 1'b0;
    read_disp;
    chk(got, 16'h0000);
    chk(gseg, {21'h0, seg7(4'h0)});
    chk(wraps[15:0], ew[15:0]);
    mode <= 2'h2;
    cyc(10);
    chk_flags(16'h9999);
    $display("test display modes done");
    test_done;
  end
endmodule
